// ===== rtl/eir_pkg.sv
// constants for the external interrupt and reset pin block
package eir_pkg;
	localparam logic [12:0] EIR_ISC_ADDR = 13'h000d;
	localparam logic [12:0] EIR_IO_LAST = 13'h001f;
	// status/control bit positions
	localparam int EIR_BIT_ENABLE = 1;
	localparam int EIR_BIT_ACK = 2;
	localparam int EIR_BIT_PEND = 3;
	localparam logic [7:0] EIR_ISC_RESET = 8'h02;
	// option byte bit positions
	localparam int EIR_OPT_LEVEL = 0;
	localparam int EIR_OPT_MERGE = 1;
	localparam logic [7:0] EIR_OPT_RESET = 8'h00;
	// cycles the reset pin is driven low after an internal reset
	localparam logic [3:0] EIR_RST_DRIVE_CYC = 4'h8;
	typedef enum logic [1:0] {
		EIR_RUN = 2'b00,
		EIR_DRIVE = 2'b01
	} eir_rst_e;
endpackage

// ===== rtl/eir_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module eir_sync (
	input wire logic clk,
	input wire logic d,
	output logic q
);
	logic meta_reg;
	// first stage is read only by the second
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q <= meta_reg;
	end
endmodule
`default_nettype wire

// ===== rtl/eir_top.sv
// external interrupt request and bidirectional reset pin logic
// How it works
// (RL1) a low reset pin puts all but the pin-drive sequencer (rst_st, rst_cnt, drive) back into its startup state.
// (RL2) watchdog, illegal address and low-voltage resets drive the reset pin low.
// (RL3) the interrupt pin's falling edge is caught by an asynchronous latch with no clock, then synchronised into its request.
// (RL4) an option bit picks falling-edge-only or falling-edge-plus-low-level sensing.
// (RL5) with the merge option set, the four keypad port pins are ORed into the request.
// (RL6) keypad pins are active on rising edges and high levels.
// (RL7) the edge/level choice applies to keypad pins and the interrupt pin alike.
// (RL8) the status/control register is decoded at address 000d.
// (RL9) in edge mode a detected edge sets a pending latch held until acknowledged.
`timescale 1ns/10ps
`default_nettype none
module eir_top
	import eir_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic irq_n_pin,
	input wire logic [3:0] keypad_port_pins,
	input wire logic reset_n_pin_in,
	output logic reset_n_pin_out,
	output logic reset_n_pin_oe,
	input wire logic watchdog_timer_rst,
	input wire logic illegal_addr_rst,
	input wire logic low_volt_rst,
	input wire logic [7:0] option_byte_reg,
	input wire logic [12:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic cpu_irq_req,
	output logic chip_reset
);
	typedef struct packed {
		eir_rst_e rst_st;
		logic [3:0] rst_cnt;
		logic pend;
		logic enable;
		logic active_prev;
		logic [7:0] rdata;
		logic irq;
		logic drive;
		logic chip_rst;
	} eir_state_s;

	eir_state_s st_reg, st_next;
	logic irq_s, rst_s;
	logic [3:0] kp_s;
	logic async_edge;

	eir_sync u_irq (.clk(clk), .d(irq_n_pin), .q(irq_s));
	eir_sync u_rst (.clk(clk), .d(reset_n_pin_in), .q(rst_s));
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_kp
			eir_sync u_kp (.clk(clk), .d(keypad_port_pins[g]), .q(kp_s[g]));
		end
	endgenerate

	// falling irq pin edge caught without a clock, cleared from the clocked side
	logic async_clr;
	always_ff @(negedge irq_n_pin or posedge async_clr) begin
		if (async_clr) begin
			async_edge <= 1'b0;
		end else begin
			async_edge <= 1'b1; // [RL3]
		end
	end
	// clear built from registered terms only, so no combinational glitch can reach the async clear
	// the clear dominates while pend is set: further pin edges are folded into the one request
	assign async_clr = st_reg.chip_rst | st_reg.pend;

	// the latch output belongs to the pin's timing, not the clock's,
	// so it passes two flops before any clocked logic reads it
	// limitation: an acknowledge within two cycles of the edge can see the stale latch again
	logic async_edge_s;
	eir_sync u_aedge (.clk(clk), .d(async_edge), .q(async_edge_s));

	logic level_mode, merge_on, active_now, edge_seen, isc_hit, any_int;
	always_comb begin
		level_mode = option_byte_reg[EIR_OPT_LEVEL]; // [RL4]
		merge_on = option_byte_reg[EIR_OPT_MERGE];
		// keypad inverted polarity, same sensing path as irq pin
		active_now = ~irq_s | (merge_on & (|kp_s)); // [RL5] [RL6] [RL7]
		// synchronous edge for slow edges, latched edge for pulses shorter than a clock
		edge_seen = (active_now & ~st_reg.active_prev) | async_edge_s;
		isc_hit = (bus_addr == EIR_ISC_ADDR); // [RL8]
		any_int = watchdog_timer_rst | illegal_addr_rst | low_volt_rst;
		st_next = st_reg;
		st_next.active_prev = active_now;
		// set wins over the acknowledge
		if (bus_wr & isc_hit) begin
			st_next.enable = bus_wdata[EIR_BIT_ENABLE];
			if (bus_wdata[EIR_BIT_ACK]) begin
				st_next.pend = 1'b0;
			end
		end
		if (edge_seen) begin
			st_next.pend = 1'b1; // [RL9]
		end
		st_next.irq = st_next.enable & (st_next.pend | (level_mode & active_now)); // [RL4]
		st_next.rdata = 8'h00;
		if (bus_rd & isc_hit) begin
			st_next.rdata[EIR_BIT_ENABLE] = st_reg.enable;
			st_next.rdata[EIR_BIT_PEND] = st_reg.pend;
		end
		// internal reset drives the pin low for a fixed time
		case (st_reg.rst_st)
			EIR_RUN: begin
				if (any_int) begin
					st_next.rst_st = EIR_DRIVE; // [RL2]
					st_next.rst_cnt = EIR_RST_DRIVE_CYC;
				end
			end
			EIR_DRIVE: begin
				if (st_reg.rst_cnt == 4'h1 && !any_int) begin
					st_next.rst_st = EIR_RUN;
				end else if (any_int) begin
					st_next.rst_cnt = EIR_RST_DRIVE_CYC;
				end else begin
					st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
				end
			end
			default: st_next.rst_st = EIR_RUN;
		endcase
		st_next.drive = (st_next.rst_st == EIR_DRIVE); // [RL2]
		st_next.chip_rst = ~rst_s | st_next.drive; // [RL1]
	end

	always_ff @(posedge clk) begin
		if (srst | ~rst_s) begin
			st_reg <= '0; // [RL1]
			st_reg.enable <= EIR_ISC_RESET[EIR_BIT_ENABLE];
			st_reg.chip_rst <= 1'b1;
			st_reg.active_prev <= 1'b1;
			st_reg.drive <= srst ? 1'b0 : st_next.drive;
			st_reg.rst_st <= srst ? EIR_RUN : st_next.rst_st;
			st_reg.rst_cnt <= srst ? 4'h0 : st_next.rst_cnt;
		end else begin
			st_reg <= st_next;
		end
	end

	// every output but the constant-low reset_n_pin_out straight from the state register
	assign bus_rdata = st_reg.rdata;
	assign cpu_irq_req = st_reg.irq;
	// the pin is only ever pulled low; the pull-up restores it when oe drops
	assign reset_n_pin_out = 1'b0;
	assign reset_n_pin_oe = st_reg.drive;
	assign chip_reset = st_reg.chip_rst;

	// one check per rule RL1 to RL9, the internal reset drive first
	// the drive window restarts on every new request, so only its length is watched
	chk_pin_drive: assert property (@(posedge clk) disable iff (srst)
		$rose(any_int) |=> reset_n_pin_oe [*8]) else $error("reset pin not driven"); // [RL2]
	chk_isc_read: assert property (@(posedge clk) disable iff (srst)
		(bus_rd && bus_addr != EIR_ISC_ADDR) |=> bus_rdata == 8'h00) else $error("bad decode"); // [RL8]
	chk_edge_latch: assert property (@(posedge clk) disable iff (srst || !rst_s)
		(active_now && !st_reg.active_prev && !chip_reset) |=> st_reg.pend) else $error("edge lost"); // [RL9]
	chk_edge_only: assert property (@(posedge clk) disable iff (srst)
		(!option_byte_reg[EIR_OPT_LEVEL] && !st_next.pend) |=> !cpu_irq_req) else $error("level leak"); // [RL4]
	chk_reset_in: assert property (@(posedge clk) disable iff (srst)
		!rst_s |=> chip_reset && !cpu_irq_req) else $error("reset pin ignored"); // [RL1]
	chk_keypad_merge: assert property (@(posedge clk) disable iff (srst)
		(!option_byte_reg[EIR_OPT_MERGE] && irq_s) |-> !active_now) else $error("merge leak"); // [RL5]
	chk_keypad_pol: assert property (@(posedge clk) disable iff (srst)
		(option_byte_reg[EIR_OPT_MERGE] && |kp_s) |-> active_now) else $error("keypad polarity"); // [RL6]
	chk_level_both: assert property (@(posedge clk) disable iff (srst || !rst_s)
		(option_byte_reg[EIR_OPT_LEVEL] && active_now && st_reg.enable && !chip_reset) |=> cpu_irq_req)
		else $error("level missed"); // [RL7]
	chk_async_edge: assert property (@(posedge clk) disable iff (srst || !rst_s)
		(async_edge_s && !chip_reset) |=> st_reg.pend) else $error("async edge lost"); // [RL3]

	// drive ends when the count runs out with no new request
	chk_drive_end: assert property (@(posedge clk) disable iff (srst)
		(st_reg.rst_st == EIR_DRIVE && st_reg.rst_cnt == 4'h1 && !any_int) |=> !reset_n_pin_oe)
		else $error("drive too long"); // [RL2]
	// no drive without a request while idle
	chk_oe_idle: assert property (@(posedge clk) disable iff (srst)
		(st_reg.rst_st == EIR_RUN && !any_int) |=> !reset_n_pin_oe) else $error("spurious drive"); // [RL2]
	// while the pin is pulled low the chip itself is in reset
	chk_drive_rst: assert property (@(posedge clk) disable iff (srst)
		reset_n_pin_oe |-> chip_reset) else $error("drive without reset"); // [RL2]

	// pending latch: cleared by an acknowledge or a low reset pin, held otherwise
	chk_ack_clear: assert property (@(posedge clk) disable iff (srst)
		(bus_wr && isc_hit && bus_wdata[EIR_BIT_ACK] && !edge_seen) |=> !st_reg.pend)
		else $error("ack ignored"); // [RL9]
	chk_pend_hold: assert property (@(posedge clk) disable iff (srst)
		(st_reg.pend && rst_s && !(bus_wr && isc_hit && bus_wdata[EIR_BIT_ACK])) |=> st_reg.pend)
		else $error("pending lost"); // [RL9]
	// a cleared enable masks the request
	chk_irq_mask: assert property (@(posedge clk) disable iff (srst)
		!st_next.enable |=> !cpu_irq_req) else $error("masked request"); // [RL3]

	// register decode: writes land, reads show the state of the cycle before
	chk_enable_wr: assert property (@(posedge clk) disable iff (srst)
		(bus_wr && isc_hit && rst_s) |=> st_reg.enable == $past(bus_wdata[EIR_BIT_ENABLE]))
		else $error("enable write lost"); // [RL8]
	chk_isc_data: assert property (@(posedge clk) disable iff (srst)
		(bus_rd && isc_hit && rst_s) |=> bus_rdata == {4'h0, $past(st_reg.pend), 1'b0, $past(st_reg.enable), 1'b0})
		else $error("read data wrong"); // [RL8]
endmodule
`default_nettype wire

// ===== bench/eir_src.sv
// pin-side sources: interrupt line driven directly, reset pin with a pull-up
`timescale 1ns/10ps
`default_nettype none
module eir_src (
	input wire logic irq_drv_n,
	input wire logic ext_rst_n,
	input wire logic oe,
	input wire logic rst_o,
	output logic irq_n,
	output logic rst_n
);
	// pull-up wins only when nobody pulls the line low
	assign irq_n = irq_drv_n;
	assign rst_n = (oe ? rst_o : 1'b1) & ext_rst_n;
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the interrupt and reset pin block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import eir_pkg::*;
	logic clk, srst, irq_drv_n, ext_rst_n, wd, ia, lv, wr, rd;
	logic [3:0] kp;
	logic [7:0] opt, wdat, rdat, lfsr;
	logic [12:0] addr;
	wire logic irq_n, rst_n, rst_o, oe, req, crst;
	wire logic [7:0] bus_rdata;
	int fail_count, cmp_count;
	eir_src u_src(.irq_drv_n(irq_drv_n), .ext_rst_n(ext_rst_n), .oe(oe), .rst_o(rst_o), .irq_n(irq_n), .rst_n(rst_n));
	eir_top u_dut(.clk(clk), .srst(srst), .irq_n_pin(irq_n), .keypad_port_pins(kp), .reset_n_pin_in(rst_n),
		.reset_n_pin_out(rst_o), .reset_n_pin_oe(oe), .watchdog_timer_rst(wd), .illegal_addr_rst(ia),
		.low_volt_rst(lv), .option_byte_reg(opt), .bus_addr(addr), .bus_wr(wr), .bus_rd(rd),
		.bus_wdata(wdat), .bus_rdata(bus_rdata), .cpu_irq_req(req), .chip_reset(crst));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// fibonacci step, taps 8 6 5 4
	function automatic logic [7:0] lfsr_step(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one-cycle strobe; read data lands the cycle after
	task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 rdat = bus_rdata;
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000 fail_count++;
		stop_test;
	end
	initial begin
		{srst, irq_drv_n, ext_rst_n, wd, ia, lv, wr, rd} = 8'he0;
		{kp, opt, wdat, addr} = '0;
		lfsr = 8'h5d;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		wt(4);
		chk(crst, 0);
		acc(0, EIR_ISC_ADDR, 0);
		chk(rdat, EIR_ISC_RESET);
		// write elsewhere, then a read at that same address must return zero
		lfsr = lfsr_step(lfsr);
		acc(1, 13'h000c, lfsr);
		acc(0, 13'h000c, 0);
		chk(rdat, 0);
		// one-cycle low pulse: too short for level, kept by the latch
		@(posedge clk) irq_drv_n <= 1'b0;
		@(posedge clk) irq_drv_n <= 1'b1;
		wt(6);
		chk(req, 1);
		acc(0, EIR_ISC_ADDR, 0);
		chk(rdat, 8'h0a);
		acc(1, EIR_ISC_ADDR, 8'h06);
		wt(3);
		chk(req, 0);
		// level mode: a held low pin survives acknowledge
		opt <= 8'h01;
		irq_drv_n <= 1'b0;
		wt(6);
		acc(1, EIR_ISC_ADDR, 8'h06);
		wt(3);
		chk(req, 1);
		irq_drv_n <= 1'b1;
		wt(6);
		chk(req, 0);
		// keypad pins: ignored unless merged, active high
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_step(lfsr);
			opt <= 8'h00;
			kp <= lfsr[3:0] | 4'h1;
			wt(6);
			chk(req, 0);
			kp <= 4'h0;
			opt <= {6'h0, 1'b1, i[0]};
			wt(4);
			kp <= 4'h1 << i;
			wt(6);
			acc(1, EIR_ISC_ADDR, 8'h06);
			wt(3);
			chk(req, {7'h0, i[0]});
			kp <= 4'h0;
			wt(4);
			acc(1, EIR_ISC_ADDR, 8'h06);
			wt(3);
			chk(req, 0);
		end
		// each internal reset source pulls the pin low
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) {wd, ia, lv} <= 3'h1 << i;
			@(posedge clk) {wd, ia, lv} <= 3'h0;
			wt(2);
			chk({oe, rst_n}, 8'h02);
			wt(30);
			chk({oe, crst}, 0);
		end
		ext_rst_n <= 1'b0;
		wt(4);
		chk(crst, 1);
		ext_rst_n <= 1'b1;
		wt(6);
		acc(0, EIR_ISC_ADDR, 0);
		chk(rdat, EIR_ISC_RESET);
		stop_test;
	end
endmodule
`default_nettype wire
